/* common/cmad_cfg.svh */
// Address map, field positions, reset values and widths for the decoder
`ifndef CMAD_CFG_SVH
`define CMAD_CFG_SVH
`define CMAD_PC_W 23
`define CMAD_PADDR_W 24
`define CMAD_PC_RESET 23'h000000
`define CMAD_PC_STEP 23'h000002
`define CMAD_USER_PROG_TOP 24'h02abff
`define CMAD_VECTOR_TOP 24'h000200
`define CMAD_TBLPAGE_CFG_BIT 7
`define CMAD_EA_W 16
`define CMAD_XADDR_W 24
`define CMAD_RD_PAGE_W 10
`define CMAD_WR_PAGE_W 9
`define CMAD_RD_PAGE_RESET 10'h001
`define CMAD_WR_PAGE_RESET 9'h001
`define CMAD_PAGE_SEL_BIT 15
`define CMAD_SFR_TOP 24'h000fff
`define CMAD_NEAR_TOP 16'h1fff
`define CMAD_NEAR_FIELD_W 13
`define CMAD_RAM_BASE 24'h001000
`define CMAD_IMPL_TOP 24'h004fff
`define CMAD_RAM_WORDS 8192
`define CMAD_RAM_IDX_W 13
`define CMAD_XY_BOUND 24'h003000
`endif

/* common/cmad_pkg.sv */
// Types shared by the memory address decoder and its data memory
package cmad_pkg;
	typedef enum logic [3:0] {
		CMAD_PSRC_PC = 4'b0001,
		CMAD_PSRC_TBL_RD = 4'b0010,
		CMAD_PSRC_TBL_WR = 4'b0100,
		CMAD_PSRC_REMAP = 4'b1000
	} cmad_psrc_type;
	typedef enum logic [2:0] {
		CMAD_EA_NEAR = 3'b001,
		CMAD_EA_DIRECT = 3'b010,
		CMAD_EA_INDIRECT = 3'b100
	} cmad_easrc_type;
	typedef enum logic [2:0] {
		CMAD_EXT_NONE = 3'b001,
		CMAD_EXT_SIGN = 3'b010,
		CMAD_EXT_ZERO = 3'b100
	} cmad_ext_type;
	typedef struct packed {
		logic rd;
		logic wr;
		logic word;
		logic fp_sp;
		cmad_easrc_type src;
		logic [15:0] field;
		logic [15:0] wdata;
	} cmad_dreq_type;
	typedef struct packed {
		logic en;
		logic [15:0] start;
		logic [15:0] stop;
		logic brev;
		logic [15:0] brev_mod;
	} cmad_modulo_type;
endpackage : cmad_pkg

/* hdl/cmad_dram.sv */
// Dual-read data RAM with byte write lanes and registered read data
`timescale 1ns/1ps
`default_nettype none
module cmad_dram import cmad_pkg::*; #(
	parameter int WORDS = 8192,
	parameter int IW = 13
) (
	input wire logic clk,
	input wire logic [IW-1:0] a_idx,
	input wire logic [1:0] a_be,
	input wire logic [15:0] a_wdata,
	output logic [15:0] a_rdata,
	input wire logic [IW-1:0] b_idx,
	output logic [15:0] b_rdata
);
	logic [7:0] lane_lo [0:WORDS-1];
	logic [7:0] lane_hi [0:WORDS-1];

	// Two byte-wide arrays share one word decode
	always_ff @(posedge clk) begin
		if (a_be[0]) begin
			lane_lo[a_idx] <= a_wdata[7:0];
		end
		if (a_be[1]) begin
			lane_hi[a_idx] <= a_wdata[15:8];
		end
	end

	always_ff @(posedge clk) begin
		a_rdata <= {lane_hi[a_idx], lane_lo[a_idx]};
		b_rdata <= {lane_hi[b_idx], lane_lo[b_idx]};
	end
endmodule : cmad_dram
`default_nettype wire

/* hdl/cmad_top.sv */
// Program and data address decode between the core and its memories
`timescale 1ns/1ps
`default_nettype none
`include "cmad_cfg.svh"
module cmad_top import cmad_pkg::*; #(
	parameter logic [23:0] XY_BOUND = `CMAD_XY_BOUND,
	parameter int RAM_WORDS = `CMAD_RAM_WORDS
) (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic PC_LOAD,
	input wire logic [22:0] PC_LOAD_VAL,
	input wire logic PC_STEP_FWD,
	input wire logic PC_STEP_BACK,
	output logic [22:0] PC_OUT,
	input wire cmad_psrc_type PROG_SRC,
	input wire logic [7:0] TABLE_PAGE_REG,
	input wire logic [15:0] TABLE_OFFSET,
	input wire logic [23:0] REMAP_ADDR,
	output logic [23:0] PROG_ADDR,
	output logic PROG_ALLOWED,
	input wire logic [23:0] PROG_RDATA,
	output logic [15:0] PROG_WORD,
	input wire cmad_dreq_type XREQ,
	input wire logic MULTIPLY_ACCUMULATE_CLASS,
	input wire logic Y_RD,
	input wire logic [15:0] Y_EA,
	input wire logic [9:0] DATA_READ_PAGE_REG,
	input wire logic [8:0] DATA_WRITE_PAGE_REG,
	input wire logic STACK_FRAME_ACTIVE,
	input wire cmad_modulo_type MODULO,
	input wire logic [15:0] WREG_OLD,
	input wire cmad_ext_type LOAD_EXT,
	output logic [11:0] SFR_ADDR,
	output logic SFR_RD,
	input wire logic SFR_HIT,
	input wire logic [15:0] SFR_RDATA,
	output logic [1:0] SFR_WR_BE,
	output logic [11:0] SFR_WADDR,
	output logic [15:0] SFR_WDATA,
	output logic X_RVALID,
	output logic [15:0] X_RDATA,
	output logic [15:0] Y_RDATA,
	output logic [15:0] WREG_NEW,
	output logic [15:0] PTR_NEXT,
	output logic ADDR_TRAP
);
	function automatic logic [15:0] rev16(input logic [15:0] v);
		logic [15:0] r;
		r = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			r[i] = v[15-i];
		end
		return r;
	endfunction : rev16

	function automatic logic [23:0] extend_ea(input logic [15:0] ea,
			input logic [9:0] page, input logic bypass);
		logic [23:0] x;
		x = {8'h00, ea};
		// Pages at 0x200 and above map program space, not decoded here
		if (ea[`CMAD_PAGE_SEL_BIT] && !bypass) begin
			x = (page == 10'h000 || page[9]) ? 24'hffffff :
				{page[8:0], ea[14:0]};
		end
		return x;
	endfunction : extend_ea

	function automatic logic [`CMAD_RAM_IDX_W-1:0] ram_index(
			input logic [23:0] x);
		logic [23:0] off;
		off = x - `CMAD_RAM_BASE;
		return off[`CMAD_RAM_IDX_W:1];
	endfunction : ram_index

	function automatic logic in_ram(input logic [23:0] x);
		return x >= `CMAD_RAM_BASE && x <= `CMAD_IMPL_TOP;
	endfunction : in_ram

	// Program counter
	logic [22:0] pc_r;
	always_ff @(posedge MCLK) begin
		if (RST) begin
			pc_r <= `CMAD_PC_RESET;
		end else if (PC_LOAD) begin
			pc_r <= {PC_LOAD_VAL[22:1], 1'b0};
		end else if (PC_STEP_FWD) begin
			pc_r <= pc_r + `CMAD_PC_STEP;
		end else if (PC_STEP_BACK) begin
			pc_r <= pc_r - `CMAD_PC_STEP;
		end
	end
	assign PC_OUT = pc_r;

	// Program address selection and user-space limit
	logic [23:0] paddr_nxt;
	logic pallow_nxt;
	always_comb begin
		paddr_nxt = {1'b0, pc_r};
		pallow_nxt = 1'b0;
		case (PROG_SRC)
		CMAD_PSRC_PC: begin
			paddr_nxt = {1'b0, pc_r};
		end
		CMAD_PSRC_TBL_RD, CMAD_PSRC_TBL_WR: begin
			paddr_nxt = {TABLE_PAGE_REG, TABLE_OFFSET};
		end
		CMAD_PSRC_REMAP: begin
			paddr_nxt = REMAP_ADDR;
		end
		default: begin
			paddr_nxt = {1'b0, pc_r};
		end
		endcase
		pallow_nxt = paddr_nxt <= `CMAD_USER_PROG_TOP;
		// Configuration space only through table operations
		if (PROG_SRC != CMAD_PSRC_PC && PROG_SRC != CMAD_PSRC_REMAP &&
				TABLE_PAGE_REG[`CMAD_TBLPAGE_CFG_BIT]) begin
			pallow_nxt = 1'b1;
		end
	end

	logic [23:0] prog_addr_r;
	logic prog_allowed_r;
	logic prog_upper_r;
	logic [15:0] prog_word_r;
	always_ff @(posedge MCLK) begin
		if (RST) begin
			prog_addr_r <= 24'h000000;
			prog_allowed_r <= 1'b0;
			prog_upper_r <= 1'b0;
		end else begin
			prog_addr_r <= paddr_nxt;
			prog_allowed_r <= pallow_nxt;
			prog_upper_r <= paddr_nxt[0];
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			prog_word_r <= 16'h0000;
		end else if (!prog_allowed_r) begin
			prog_word_r <= 16'h0000;
		end else if (prog_upper_r) begin
			prog_word_r <= {8'h00, PROG_RDATA[23:16]};
		end else begin
			prog_word_r <= PROG_RDATA[15:0];
		end
	end
	assign PROG_ADDR = prog_addr_r;
	assign PROG_ALLOWED = prog_allowed_r;
	assign PROG_WORD = prog_word_r;

	// X effective address, misalignment and write strobes
	logic [15:0] x_ea;
	logic [23:0] x_ext;
	logic x_misalign;
	logic [1:0] x_be;
	logic [15:0] x_wlanes;
	always_comb begin
		case (XREQ.src)
		CMAD_EA_NEAR: begin
			x_ea = {3'b000, XREQ.field[`CMAD_NEAR_FIELD_W-1:0]};
		end
		CMAD_EA_DIRECT, CMAD_EA_INDIRECT: begin
			x_ea = XREQ.field;
		end
		default: begin
			x_ea = XREQ.field;
		end
		endcase
		// Separate page per direction; frame/stack pointers may bypass
		x_ext = extend_ea(x_ea, XREQ.wr ? {1'b0, DATA_WRITE_PAGE_REG} :
			DATA_READ_PAGE_REG,
			STACK_FRAME_ACTIVE && XREQ.fp_sp);
		x_misalign = XREQ.word && x_ea[0];
		x_be = 2'b00;
		x_wlanes = XREQ.wdata;
		if (XREQ.wr && !x_misalign) begin
			if (XREQ.word) begin
				x_be = 2'b11;
			end else begin
				x_be = x_ea[0] ? 2'b10 : 2'b01;
				x_wlanes = {XREQ.wdata[7:0], XREQ.wdata[7:0]};
			end
		end
	end

	// Writes see X and Y as one space
	logic [1:0] ram_be;
	assign ram_be = in_ram(x_ext) ? x_be : 2'b00;
	assign SFR_ADDR = x_ext[11:0];
	assign SFR_RD = XREQ.rd && x_ext <= `CMAD_SFR_TOP;

	logic [1:0] sfr_be_r;
	logic [11:0] sfr_waddr_r;
	logic [15:0] sfr_wdata_r;
	always_ff @(posedge MCLK) begin
		if (RST) begin
			sfr_be_r <= 2'b00;
			sfr_waddr_r <= 12'h000;
			sfr_wdata_r <= 16'h0000;
		end else begin
			sfr_be_r <= (x_ext <= `CMAD_SFR_TOP) ? x_be : 2'b00;
			sfr_waddr_r <= x_ext[11:0];
			sfr_wdata_r <= x_wlanes;
		end
	end
	assign SFR_WR_BE = sfr_be_r;
	assign SFR_WADDR = sfr_waddr_r;
	assign SFR_WDATA = sfr_wdata_r;

	// Y read address, only meaningful in Y space for the multiply class
	logic [23:0] y_ext;
	logic y_ok;
	assign y_ext = extend_ea(Y_EA, DATA_READ_PAGE_REG, 1'b0);
	assign y_ok = Y_RD && MULTIPLY_ACCUMULATE_CLASS && in_ram(y_ext) &&
		y_ext >= XY_BOUND;

	logic [15:0] ram_a_rdata;
	logic [15:0] ram_b_rdata;
	cmad_dram #(.WORDS(RAM_WORDS), .IW(`CMAD_RAM_IDX_W)) u_dram (
		.clk(MCLK),
		.a_idx(ram_index(x_ext)),
		.a_be(ram_be),
		.a_wdata(x_wlanes),
		.a_rdata(ram_a_rdata),
		.b_idx(ram_index(y_ext)),
		.b_rdata(ram_b_rdata)
	);

	// Pointer post-modify with modulo and X-write bit reversal
	logic [15:0] ptr_nxt;
	always_comb begin
		ptr_nxt = XREQ.field + (XREQ.word ? 16'h0002 : 16'h0001);
		if (XREQ.wr && MODULO.brev && XREQ.word) begin
			ptr_nxt = rev16(rev16(XREQ.field) + rev16(MODULO.brev_mod));
		end else if (MODULO.en && ptr_nxt > MODULO.stop) begin
			ptr_nxt = MODULO.start;
		end
	end

	// Stage 1: memory access in flight
	logic s1_valid_r;
	logic s1_trap_r;
	logic s1_word_r;
	logic s1_hi_r;
	logic s1_ram_r;
	logic s1_sfr_r;
	logic s1_y_r;
	logic [15:0] s1_sfr_data_r;
	logic [15:0] s1_ptr_r;
	logic [15:0] s1_wold_r;
	cmad_ext_type s1_ext_r;
	logic x_space_ok;
	assign x_space_ok = !MULTIPLY_ACCUMULATE_CLASS || x_ext < XY_BOUND;
	always_ff @(posedge MCLK) begin
		if (RST) begin
			s1_valid_r <= 1'b0;
			s1_trap_r <= 1'b0;
		end else begin
			s1_valid_r <= XREQ.rd;
			s1_trap_r <= (XREQ.rd || XREQ.wr) && x_misalign;
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			s1_word_r <= 1'b0;
			s1_hi_r <= 1'b0;
			s1_ram_r <= 1'b0;
			s1_sfr_r <= 1'b0;
			s1_y_r <= 1'b0;
			s1_sfr_data_r <= 16'h0000;
			s1_ptr_r <= 16'h0000;
			s1_wold_r <= 16'h0000;
			s1_ext_r <= CMAD_EXT_NONE;
		end else begin
			s1_word_r <= XREQ.word;
			s1_hi_r <= x_ea[0];
			s1_ram_r <= in_ram(x_ext) && x_space_ok;
			s1_sfr_r <= SFR_RD && SFR_HIT;
			s1_y_r <= y_ok;
			s1_sfr_data_r <= SFR_RDATA;
			s1_ptr_r <= ptr_nxt;
			s1_wold_r <= WREG_OLD;
			s1_ext_r <= LOAD_EXT;
		end
	end

	// Stage 2: lane select, zero fill and register merge
	logic [15:0] word_sel;
	logic [15:0] rd_nxt;
	logic [15:0] wreg_nxt;
	always_comb begin
		word_sel = 16'h0000;
		if (s1_ram_r) begin
			word_sel = ram_a_rdata;
		end else if (s1_sfr_r) begin
			word_sel = s1_sfr_data_r;
		end
		// Misaligned read still completes using the containing word
		rd_nxt = word_sel;
		if (!s1_word_r) begin
			rd_nxt = {8'h00, s1_hi_r ? word_sel[15:8] : word_sel[7:0]};
		end
		wreg_nxt = rd_nxt;
		if (!s1_word_r) begin
			case (s1_ext_r)
			CMAD_EXT_NONE: begin
				wreg_nxt = {s1_wold_r[15:8], rd_nxt[7:0]};
			end
			CMAD_EXT_SIGN: begin
				wreg_nxt = {{8{rd_nxt[7]}}, rd_nxt[7:0]};
			end
			CMAD_EXT_ZERO: begin
				wreg_nxt = {8'h00, rd_nxt[7:0]};
			end
			default: begin
				wreg_nxt = {s1_wold_r[15:8], rd_nxt[7:0]};
			end
			endcase
		end
	end

	logic x_rvalid_r;
	logic trap_r;
	logic [15:0] x_rdata_r;
	logic [15:0] y_rdata_r;
	logic [15:0] wreg_r;
	logic [15:0] ptr_r;
	always_ff @(posedge MCLK) begin
		if (RST) begin
			x_rvalid_r <= 1'b0;
			trap_r <= 1'b0;
			x_rdata_r <= 16'h0000;
			y_rdata_r <= 16'h0000;
			wreg_r <= 16'h0000;
			ptr_r <= 16'h0000;
		end else begin
			x_rvalid_r <= s1_valid_r;
			trap_r <= s1_trap_r;
			x_rdata_r <= rd_nxt;
			y_rdata_r <= s1_y_r ? ram_b_rdata : 16'h0000;
			wreg_r <= wreg_nxt;
			ptr_r <= s1_ptr_r;
		end
	end
	assign X_RVALID = x_rvalid_r;
	assign ADDR_TRAP = trap_r;
	assign X_RDATA = x_rdata_r;
	assign Y_RDATA = y_rdata_r;
	assign WREG_NEW = wreg_r;
	assign PTR_NEXT = ptr_r;

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);

	sequence s_misaligned;
		(XREQ.rd || XREQ.wr) && XREQ.word && x_ea[0];
	endsequence
	sequence s_byte_read;
		XREQ.rd && !XREQ.word;
	endsequence

	a_pc_reset_vector: assert property ($past(RST) |-> PC_OUT == 23'h0)
		else $error("PC not at reset vector after reset");
	a_pc_step_two: assert property (PC_STEP_FWD && !PC_LOAD |=>
		PC_OUT == $past(PC_OUT) + 23'h000002)
		else $error("PC did not advance by two");
	a_pc_even: assert property (PC_OUT[0] == 1'b0)
		else $error("PC odd");
	a_prog_user_cap: assert property (PROG_SRC == CMAD_PSRC_PC &&
		pc_r > 23'h02abff |=> !PROG_ALLOWED)
		else $error("Program access above user limit allowed");
	a_misalign_no_strobe: assert property (s_misaligned |->
		ram_be == 2'b00 ##1 SFR_WR_BE == 2'b00)
		else $error("Write strobe on misaligned word");
	a_misalign_trap: assert property (s_misaligned |-> ##2 ADDR_TRAP)
		else $error("Misaligned access without trap");
	a_byte_low_lane: assert property (s_byte_read |->
		##2 X_RVALID && X_RDATA[15:8] == 8'h00)
		else $error("Byte read not on low lane");
	a_unimpl_zero: assert property (XREQ.rd && x_ext > 24'h004fff |->
		##2 X_RDATA == 16'h0000)
		else $error("Unimplemented read not zero");
	a_byte_strobe: assert property (XREQ.wr && !XREQ.word &&
		in_ram(x_ext) |-> ram_be == (x_ea[0] ? 2'b10 : 2'b01))
		else $error("Byte write strobe on wrong lane");
	a_ptr_step: assert property (XREQ.rd && !MODULO.en &&
		!XREQ.wr |-> ##2 PTR_NEXT == $past(XREQ.field, 2) +
		($past(XREQ.word, 2) ? 16'h0002 : 16'h0001))
		else $error("Pointer step not scaled by size");
	a_byte_merge: assert property (XREQ.rd && !XREQ.word &&
		LOAD_EXT == CMAD_EXT_NONE
		|-> ##2 WREG_NEW[15:8] == $past(WREG_OLD[15:8], 2))
		else $error("Byte load altered high byte");
endmodule : cmad_top
`default_nettype wire

/* tb/cmad_sfr_model.sv */
// Register-space responder standing behind the decoder's register port
`timescale 1ns/1ps
`default_nettype none
module cmad_sfr_model (
	input wire logic clk,
	input wire logic [11:0] sfr_addr,
	input wire logic sfr_rd,
	output logic sfr_hit,
	output logic [15:0] sfr_rdata,
	input wire logic [1:0] sfr_wr_be,
	input wire logic [11:0] sfr_waddr,
	input wire logic [15:0] sfr_wdata
);
	logic [15:0] reg_r = 16'h0000;
	logic [15:0] junk_r = 16'h0f0f;
	// One word implemented; the rest of the region is unused
	always_comb begin
		sfr_hit = sfr_rd && (sfr_addr[11:1] == 11'h400);
		sfr_rdata = sfr_hit ? reg_r : junk_r;
	end
	// Unselected data changes each cycle so a stale value cannot pass
	always_ff @(posedge clk) begin
		junk_r <= ~junk_r + 16'h0001;
		if (sfr_waddr[11:1] == 11'h400) begin
			if (sfr_wr_be[0]) begin
				reg_r[7:0] <= sfr_wdata[7:0];
			end
			if (sfr_wr_be[1]) begin
				reg_r[15:8] <= sfr_wdata[15:8];
			end
		end
	end
endmodule : cmad_sfr_model
`default_nettype wire

/* tb/cmad_top_tb.sv */
// Self-checking bench for the memory address decoder
`timescale 1ns/1ps
`default_nettype none
module cmad_top_tb import cmad_pkg::*;;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic pc_load = 1'b0;
	logic [22:0] pc_load_val = 23'h000000;
	logic pc_fwd = 1'b0;
	logic pc_back = 1'b0;
	cmad_psrc_type prog_src = CMAD_PSRC_PC;
	logic [7:0] tbl_page = 8'h00;
	logic [15:0] tbl_off = 16'h0000;
	logic [23:0] remap = 24'h000000;
	cmad_dreq_type xreq = '0;
	cmad_modulo_type modulo = '0;
	logic mac = 1'b0;
	logic y_rd = 1'b0;
	logic [15:0] y_ea = 16'h0000;
	cmad_ext_type load_ext = CMAD_EXT_NONE;
	logic [22:0] pc_out;
	logic [23:0] prog_addr;
	logic [15:0] prog_word, sfr_rdata, sfr_wdata, x_rdata, y_rdata;
	logic [15:0] wreg_new, ptr_next;
	logic prog_ok, sfr_rd, sfr_hit, x_rvalid, addr_trap;
	logic [11:0] sfr_addr, sfr_waddr;
	logic [1:0] sfr_wr_be, be_seen;
	int n_mismatch = 0;
	int samples_checked = 0;

	always #2.5 mclk = ~mclk;

	cmad_top u_cmad_top (
		.MCLK(mclk), .RST(rst), .PC_LOAD(pc_load), .PC_LOAD_VAL(pc_load_val),
		.PC_STEP_FWD(pc_fwd), .PC_STEP_BACK(pc_back), .PC_OUT(pc_out),
		.PROG_SRC(prog_src), .TABLE_PAGE_REG(tbl_page), .TABLE_OFFSET(tbl_off),
		.REMAP_ADDR(remap), .PROG_ADDR(prog_addr), .PROG_ALLOWED(prog_ok),
		.PROG_RDATA(24'h5ac3f0), .PROG_WORD(prog_word), .XREQ(xreq),
		.MULTIPLY_ACCUMULATE_CLASS(mac), .Y_RD(y_rd), .Y_EA(y_ea),
		.DATA_READ_PAGE_REG(10'h001), .DATA_WRITE_PAGE_REG(9'h001),
		.STACK_FRAME_ACTIVE(1'b0), .MODULO(modulo), .WREG_OLD(16'hbeef),
		.LOAD_EXT(load_ext), .SFR_ADDR(sfr_addr), .SFR_RD(sfr_rd),
		.SFR_HIT(sfr_hit), .SFR_RDATA(sfr_rdata), .SFR_WR_BE(sfr_wr_be),
		.SFR_WADDR(sfr_waddr), .SFR_WDATA(sfr_wdata), .X_RVALID(x_rvalid),
		.X_RDATA(x_rdata), .Y_RDATA(y_rdata), .WREG_NEW(wreg_new),
		.PTR_NEXT(ptr_next), .ADDR_TRAP(addr_trap)
	);

	cmad_sfr_model u_cmad_sfr_model (
		.clk(mclk), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd), .sfr_hit(sfr_hit),
		.sfr_rdata(sfr_rdata), .sfr_wr_be(sfr_wr_be), .sfr_waddr(sfr_waddr),
		.sfr_wdata(sfr_wdata)
	);

	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : report_and_stop

	// One request cycle; results land two edges later, strobe one edge later
	task automatic xrun(input logic rd, input logic wr, input logic word,
		input cmad_easrc_type src, input logic [15:0] ea, input logic [15:0] wd);
		@(negedge mclk);
		xreq = '{rd, wr, word, 1'b0, src, ea, wd};
		@(negedge mclk);
		// Strobe stands only in the cycle after the request edge
		be_seen = sfr_wr_be;
		xreq = '0;
		mac = 1'b0;
		y_rd = 1'b0;
		@(negedge mclk);
	endtask : xrun

	// Word reads judge the X bus, byte reads the updated working register
	task automatic rdchk(input logic word, input logic [15:0] ea,
		input cmad_ext_type ext, input logic [15:0] exp);
		load_ext = ext;
		xrun(1'b1, 1'b0, word, CMAD_EA_DIRECT, ea, 16'h0000);
		check(x_rvalid, 1'b1);
		check(word ? x_rdata : wreg_new, exp);
	endtask : rdchk

	task automatic scn_pc();
		@(negedge mclk);
		pc_load = 1'b1;
		pc_load_val = 23'h000201;
		pc_fwd = 1'b1;
		@(negedge mclk);
		pc_load = 1'b0;
		check(pc_out, 23'h000200);
		@(negedge mclk);
		pc_fwd = 1'b0;
		pc_back = 1'b1;
		check(pc_out, 23'h000202);
		@(negedge mclk);
		pc_back = 1'b0;
		check(pc_out, 23'h000200);
	endtask : scn_pc

	task automatic scn_prog();
		cmad_psrc_type s[5] = '{CMAD_PSRC_PC, CMAD_PSRC_REMAP,
			CMAD_PSRC_TBL_RD, CMAD_PSRC_TBL_RD, CMAD_PSRC_TBL_WR};
		logic [23:0] a[5] = '{24'h02abfe, 24'h02ac00, 24'h800005,
			24'h030000, 24'h810000};
		logic ok[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
		logic [15:0] w[5] = '{16'hc3f0, 16'h0000, 16'h005a, 16'h0000,
			16'h0000};
		for (int i = 0; i < 5; i++) begin
			@(negedge mclk);
			prog_src = s[i];
			tbl_page = a[i][23:16];
			tbl_off = a[i][15:0];
			remap = a[i];
			pc_load = 1'b1;
			pc_load_val = a[i][22:0];
			repeat (4) @(negedge mclk);
			check(prog_addr, a[i]);
			check(prog_ok, ok[i]);
			if (i != 4) begin
				check(prog_word, w[i]);
			end
		end
		pc_load = 1'b0;
		prog_src = CMAD_PSRC_PC;
	endtask : scn_prog

	task automatic scn_data();
		xrun(1'b0, 1'b1, 1'b1, CMAD_EA_DIRECT, 16'h1000, 16'h1234);
		rdchk(1'b1, 16'h1000, CMAD_EXT_NONE, 16'h1234);
		rdchk(1'b0, 16'h1000, CMAD_EXT_NONE, 16'hbe34);
		rdchk(1'b0, 16'h1001, CMAD_EXT_NONE, 16'hbe12);
		xrun(1'b0, 1'b1, 1'b0, CMAD_EA_DIRECT, 16'h1001, 16'h0085);
		rdchk(1'b1, 16'h1000, CMAD_EXT_NONE, 16'h8534);
		rdchk(1'b0, 16'h1001, CMAD_EXT_SIGN, 16'hff85);
		rdchk(1'b0, 16'h1001, CMAD_EXT_ZERO, 16'h0085);
	endtask : scn_data

	task automatic scn_trap();
		xrun(1'b0, 1'b1, 1'b1, CMAD_EA_DIRECT, 16'h1002, 16'h5555);
		check(addr_trap, 1'b0);
		xrun(1'b0, 1'b1, 1'b1, CMAD_EA_DIRECT, 16'h1003, 16'hffff);
		check(addr_trap, 1'b1);
		rdchk(1'b1, 16'h1002, CMAD_EXT_NONE, 16'h5555);
		rdchk(1'b1, 16'h1001, CMAD_EXT_NONE, 16'h8534);
		check(addr_trap, 1'b1);
		xrun(1'b0, 1'b1, 1'b1, CMAD_EA_DIRECT, 16'h0801, 16'hffff);
		check(be_seen, 2'b00);
	endtask : scn_trap

	task automatic scn_space();
		xrun(1'b0, 1'b1, 1'b1, CMAD_EA_DIRECT, 16'h0800, 16'ha5a5);
		check(be_seen, 2'b11);
		xrun(1'b0, 1'b1, 1'b0, CMAD_EA_DIRECT, 16'h0801, 16'h003c);
		check(be_seen, 2'b10);
		rdchk(1'b1, 16'h0800, CMAD_EXT_NONE, 16'h3ca5);
		rdchk(1'b1, 16'h0900, CMAD_EXT_NONE, 16'h0000);
		xrun(1'b0, 1'b1, 1'b1, CMAD_EA_DIRECT, 16'h4ffe, 16'h0ff0);
		rdchk(1'b1, 16'h4ffe, CMAD_EXT_NONE, 16'h0ff0);
		rdchk(1'b1, 16'h5000, CMAD_EXT_NONE, 16'h0000);
		xrun(1'b1, 1'b0, 1'b0, CMAD_EA_INDIRECT, 16'h1000, 16'h0000);
		check(ptr_next, 16'h1001);
		xrun(1'b1, 1'b0, 1'b1, CMAD_EA_INDIRECT, 16'h1000, 16'h0000);
		check(ptr_next, 16'h1002);
		xrun(1'b1, 1'b0, 1'b1, CMAD_EA_NEAR, 16'h1000, 16'h0000);
		check(x_rdata, 16'h8534);
	endtask : scn_space

	task automatic scn_xy();
		xrun(1'b0, 1'b1, 1'b1, CMAD_EA_DIRECT, 16'h3000, 16'h7e7e);
		mac = 1'b1;
		y_rd = 1'b1;
		y_ea = 16'h3000;
		rdchk(1'b1, 16'h1000, CMAD_EXT_NONE, 16'h8534);
		check(y_rdata, 16'h7e7e);
		y_rd = 1'b1;
		rdchk(1'b1, 16'h3000, CMAD_EXT_NONE, 16'h7e7e);
		check(y_rdata, 16'h0000);
	endtask : scn_xy

	initial begin
		repeat (5) @(negedge mclk);
		check(pc_out, 23'h000000);
		check(prog_ok, 1'b0);
		rst = 1'b0;
		scn_pc();
		scn_prog();
		scn_data();
		scn_trap();
		scn_space();
		scn_xy();
		report_and_stop();
	end

	// A hang anywhere ends the run as a failure
	initial begin
		repeat (5000) @(posedge mclk);
		n_mismatch++;
		report_and_stop();
	end
endmodule : cmad_top_tb
`default_nettype wire
